// ==== logic/swt_core.sv ====
`timescale 1ns/1ps
// Function
// [R01] system keeps reference clock running and stable while enable is high
// [R02] count ring oscillator wraps; fine results derived from that count
// [R03] mode 2 only: count reference cycles to each stop, up to five
// [R04] set wrap limit flag when fine result over 63 reaches wrap limit
// [R05] set cycle limit flag when cycle count exceeds cycle limit
// [R06] any limit flag aborts the running measurement at once
// [R07] cycle counter starts on first reference edge after start
// [R08] stop edges before cycle count reaches blank value are ignored
// [R09] host programs cycle limit above the blank value
// [R10] enable input resets all digital logic
// [R11] system gives enable one clean rising edge after power-up
// [R12] calibrate one period then configured periods, store both counts
// [R13] mode 1 times start to last stop with ring and wraps only
// [R14] host uses mode 1 only for intervals under 500 ns
// [R15] mode 2: ring runs start to next reference edge, then cycles counted
// [R16] mode 2: ring runs after each stop until next reference edge
// [R17] host scales fine results by period over calibration count
// [R18] accept one to five stops as configured, store each result
// [R19] start bit raises trigger, wait start edge, then drop trigger
// [R20] wait for start edge forever, no timeout
// [R21] after last stop assert interrupt low and disable start, stop, trigger
// [R22] limit flag also asserts the interrupt output
module swt_core
   import swt_pkg::*;
(
   // clock and reset (rst is the enable pin, inverted)
   input  wire logic                              clk,
   input  wire logic                              rst,
   // host configuration
   input  wire logic                              begin_measure_bit,
   input  wire logic                              meas_mode2,
   input  wire logic [IDX_W-1:0]                  stop_count,
   input  wire logic [LEN_W-1:0]                  cal_multi_len,
   input  wire logic [CNT_W/2-1:0]                wrap_limit_hi,
   input  wire logic [CNT_W/2-1:0]                wrap_limit_lo,
   input  wire logic [CNT_W/2-1:0]                cycle_limit_hi,
   input  wire logic [CNT_W/2-1:0]                cycle_limit_lo,
   input  wire logic [CNT_W/2-1:0]                early_edge_blank_hi,
   input  wire logic [CNT_W/2-1:0]                early_edge_blank_lo,
   // front end pins
   input  wire logic                              start_pin,
   input  wire logic                              stop_pin,
   output logic                                   launch_pulse_out,
   output logic                                   done_irq_n,
   // ring oscillator macro
   input  wire logic                              ring_wrap_tgl,
   input  wire logic [PHASE_W-1:0]                ring_phase,
   output logic                                   ring_run,
   // results and status
   output logic [NUM_FINE-1:0][FINE_W-1:0]        fine_result,
   output logic [NUM_CYC-1:0][CNT_W-1:0]          ref_cycle_result,
   output logic [FINE_W-1:0]                      cal_single_count,
   output logic [FINE_W-1:0]                      cal_multi_count,
   output logic                                   wrap_limit_flag,
   output logic                                   cycle_limit_flag,
   output logic                                   busy
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   swt_state_t                 state_r;
   swt_state_t                 state_nxt;
   logic [2:0]                 start_sy_r;
   logic [2:0]                 stop_sy_r;
   logic [2:0]                 wrap_sy_r;
   logic [PHASE_W-1:0]         phase_m_r;
   logic [PHASE_W-1:0]         phase_r;
   logic [CNT_W-1:0]           wraps_r;
   logic [CNT_W-1:0]           cyc_r;
   logic [LEN_W-1:0]           cal_cnt_r;
   logic [IDX_W-1:0]           stop_idx_r;
   logic                       start_edge;
   logic                       stop_edge;
   logic                       wrap_edge;
   logic                       stop_ok;
   logic                       last_stop;
   logic                       wrap_over;
   logic                       cyc_over;
   logic                       abort;
   logic [IDX_W-1:0]           stops_want;
   logic [FINE_W-1:0]          fine_now;
   logic [CNT_W-1:0]           wrap_limit;
   logic [CNT_W-1:0]           cycle_limit;
   logic [CNT_W-1:0]           early_edge_blank;
   logic                       measuring;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // third stage only feeds edge detection; stage one is read by stage two only
   always_ff @(posedge clk) begin
      if (rst) begin // [R10]
         start_sy_r <= 3'h0;
         stop_sy_r  <= 3'h0;
         wrap_sy_r  <= 3'h0;
         phase_m_r  <= 6'h00;
         phase_r    <= 6'h00;
      end else begin
         start_sy_r <= {start_sy_r[1:0], start_pin};
         stop_sy_r  <= {stop_sy_r[1:0], stop_pin};
         wrap_sy_r  <= {wrap_sy_r[1:0], ring_wrap_tgl};
         phase_m_r  <= ring_phase;
         phase_r    <= phase_m_r;
      end
   end

   assign start_edge = start_sy_r[1] & ~start_sy_r[2];
   assign stop_edge  = stop_sy_r[1] & ~stop_sy_r[2];
   assign wrap_edge  = wrap_sy_r[1] ^ wrap_sy_r[2];

   // ----------------------------------------------------------------
   // thresholds and decisions
   // ----------------------------------------------------------------
   assign wrap_limit       = {wrap_limit_hi, wrap_limit_lo};             // [R04]
   assign cycle_limit      = {cycle_limit_hi, cycle_limit_lo};           // [R05]
   assign early_edge_blank = {early_edge_blank_hi, early_edge_blank_lo}; // [R08]

   // out of range stop counts clamp to the nearest legal value
   assign stops_want = (stop_count == IDX_ZERO) ? MIN_STOPS :
                       (stop_count > MAX_STOPS) ? MAX_STOPS : stop_count; // [R18]

   assign fine_now  = FINE_W'(wraps_r) * WRAP_UNITS + FINE_W'(phase_r); // [R02]
   assign measuring = (state_r == SWT_RING) || (state_r == SWT_FRACS) ||
                      (state_r == SWT_COUNT) || (state_r == SWT_FRACP);
   // fine / 63 >= limit is the same as wraps >= limit
   assign wrap_over = measuring && (wraps_r >= wrap_limit);              // [R04]
   assign cyc_over  = meas_mode2 && measuring && (cyc_r > cycle_limit);  // [R05]
   assign abort     = wrap_over || cyc_over;                             // [R06]
   assign stop_ok   = stop_edge && (cyc_r >= early_edge_blank);          // [R08]
   assign last_stop = (stop_idx_r + IDX_ONE) == stops_want;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         SWT_IDLE: begin
            if (begin_measure_bit) begin
               state_nxt = SWT_ARMED; // [R19]
            end
         end
         SWT_ARMED: begin
            // no timeout: only a start edge or reset leaves this state
            if (start_edge) begin // [R20]
               state_nxt = meas_mode2 ? SWT_FRACS : SWT_RING; // [R13] [R15]
            end
         end
         SWT_RING: begin
            if (abort) begin
               state_nxt = SWT_DONE; // [R06]
            end else if (stop_ok && last_stop) begin
               state_nxt = SWT_CAL1; // [R13]
            end
         end
         SWT_FRACS: begin
            if (abort) begin
               state_nxt = SWT_DONE; // [R06]
            end else begin
               state_nxt = SWT_COUNT; // [R15]
            end
         end
         SWT_COUNT: begin
            if (abort) begin
               state_nxt = SWT_DONE; // [R06]
            end else if (stop_ok) begin
               state_nxt = SWT_FRACP; // [R16]
            end
         end
         SWT_FRACP: begin
            if (abort) begin
               state_nxt = SWT_DONE; // [R06]
            end else if (last_stop) begin
               state_nxt = SWT_CAL1;
            end else begin
               state_nxt = SWT_COUNT;
            end
         end
         SWT_CAL1: begin
            state_nxt = SWT_CAL2; // [R12]
         end
         SWT_CAL2: begin
            if (cal_cnt_r == LEN_ONE || cal_multi_len <= LEN_ONE) begin
               state_nxt = SWT_DONE; // [R12]
            end
         end
         SWT_DONE: begin
            if (begin_measure_bit) begin
               state_nxt = SWT_ARMED;
            end
         end
         default: begin
            state_nxt = SWT_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin // [R10]
         state_r <= SWT_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------------------------------
   // ring oscillator control and wrap counting
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         ring_run <= 1'b0;
      end else begin
         ring_run <= (state_nxt == SWT_RING) || (state_nxt == SWT_FRACS) ||
                     (state_nxt == SWT_FRACP) || (state_nxt == SWT_CAL1) ||
                     (state_nxt == SWT_CAL2); // [R13] [R15] [R16]
      end
   end

   // wrap count restarts at the start of every ring segment; mode 1 stays in one
   // state across its stops, so leaving it must clear or calibration inherits wraps
   always_ff @(posedge clk) begin
      if (rst) begin
         wraps_r <= CNT_ZERO;
      end else if (!ring_run) begin
         wraps_r <= CNT_ZERO;
      end else if (state_r != state_nxt) begin
         wraps_r <= CNT_ZERO;
      end else if (wrap_edge) begin
         wraps_r <= wraps_r + CNT_ONE; // [R02]
      end
   end

   // ----------------------------------------------------------------
   // reference cycle counter and calibration length
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         cyc_r <= CNT_ZERO;
      end else if (state_r == SWT_ARMED) begin
         cyc_r <= CNT_ZERO;
      end else if (measuring) begin
         cyc_r <= cyc_r + CNT_ONE; // [R07]
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cal_cnt_r <= LEN_ZERO;
      end else if (state_r == SWT_CAL1) begin
         cal_cnt_r <= cal_multi_len;
      end else if (state_r == SWT_CAL2 && cal_cnt_r != LEN_ZERO) begin
         cal_cnt_r <= cal_cnt_r - LEN_ONE;
      end
   end

   // ----------------------------------------------------------------
   // results
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         stop_idx_r       <= IDX_ZERO;
         fine_result      <= '0;
         ref_cycle_result <= '0;
         cal_single_count <= FINE_ZERO;
         cal_multi_count  <= FINE_ZERO;
      end else begin
         if (state_r == SWT_ARMED && start_edge) begin
            stop_idx_r       <= IDX_ZERO;
            fine_result      <= '0;
            ref_cycle_result <= '0;
         end
         if (state_r == SWT_RING && stop_ok && !abort) begin
            fine_result[stop_idx_r] <= fine_now; // [R13] [R18]
            stop_idx_r              <= stop_idx_r + IDX_ONE;
         end
         if (state_r == SWT_FRACS && !abort) begin
            fine_result[0] <= fine_now; // [R15]
         end
         if (state_r == SWT_COUNT && stop_ok && !abort) begin
            ref_cycle_result[stop_idx_r] <= cyc_r; // [R03]
         end
         if (state_r == SWT_FRACP && !abort) begin
            fine_result[stop_idx_r + IDX_ONE] <= fine_now; // [R16] [R18]
            stop_idx_r                        <= stop_idx_r + IDX_ONE;
         end
         if (state_r == SWT_CAL1) begin
            cal_single_count <= fine_now; // [R12]
         end
         if (state_r == SWT_CAL2 && state_nxt == SWT_DONE) begin
            cal_multi_count <= fine_now; // [R12]
         end
      end
   end

   // ----------------------------------------------------------------
   // flags and pins
   // ----------------------------------------------------------------
   // flags stay until the start edge of the next measurement
   always_ff @(posedge clk) begin
      if (rst) begin
         wrap_limit_flag  <= 1'b0;
         cycle_limit_flag <= 1'b0;
      end else begin
         if (wrap_over) begin
            wrap_limit_flag <= 1'b1; // [R04]
         end else if (state_r == SWT_ARMED && start_edge) begin
            wrap_limit_flag <= 1'b0;
         end
         if (cyc_over) begin
            cycle_limit_flag <= 1'b1; // [R05]
         end else if (state_r == SWT_ARMED && start_edge) begin
            cycle_limit_flag <= 1'b0;
         end
      end
   end

   // start and stop are only looked at in their own states, so done disables them
   always_ff @(posedge clk) begin
      if (rst) begin
         launch_pulse_out <= 1'b0;
         done_irq_n       <= 1'b1;
         busy             <= 1'b0;
      end else begin
         launch_pulse_out <= (state_nxt == SWT_ARMED); // [R19] [R21]
         done_irq_n       <= (state_nxt != SWT_DONE);  // [R21] [R22]
         busy             <= (state_nxt != SWT_IDLE) && (state_nxt != SWT_DONE);
      end
   end

endmodule

// ==== inc/swt_pkg.sv ====
package swt_pkg;

   // ----------------------------------------------------------------
   // widths and sizes
   // ----------------------------------------------------------------
   localparam int           FINE_W      = 23;
   localparam int           CNT_W       = 16;
   localparam int           PHASE_W     = 6;
   localparam int           NUM_FINE    = 6;
   localparam int           NUM_CYC     = 5;
   localparam int           IDX_W       = 3;
   localparam int           LEN_W       = 8;

   // ----------------------------------------------------------------
   // constants
   // ----------------------------------------------------------------
   // delay units per ring wrap, so a fine result divided by this is the wrap count
   localparam logic [FINE_W-1:0]  WRAP_UNITS  = 23'h00003f;
   localparam logic [IDX_W-1:0]   MAX_STOPS   = 3'h5;
   localparam logic [IDX_W-1:0]   MIN_STOPS   = 3'h1;
   localparam logic [CNT_W-1:0]   CNT_ZERO    = 16'h0000;
   localparam logic [CNT_W-1:0]   CNT_ONE     = 16'h0001;
   localparam logic [FINE_W-1:0]  FINE_ZERO   = 23'h000000;
   localparam logic [IDX_W-1:0]   IDX_ZERO    = 3'h0;
   localparam logic [IDX_W-1:0]   IDX_ONE     = 3'h1;
   localparam logic [LEN_W-1:0]   LEN_ZERO    = 8'h00;
   localparam logic [LEN_W-1:0]   LEN_ONE     = 8'h01;
   localparam logic [CNT_W/2-1:0] BYTE_ZERO   = 8'h00;

   // ----------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [8:0] {
      SWT_IDLE  = 9'h001,
      SWT_ARMED = 9'h002,
      SWT_RING  = 9'h004,
      SWT_FRACS = 9'h008,
      SWT_COUNT = 9'h010,
      SWT_FRACP = 9'h020,
      SWT_CAL1  = 9'h040,
      SWT_CAL2  = 9'h080,
      SWT_DONE  = 9'h100
   } swt_state_t;

endpackage

// ==== testbench/swt_core_monitor.sv ====
`timescale 1ns/1ps
module swt_core_monitor
   import swt_pkg::*;
(
   // clock and reset
   input wire logic                       clk,
   input wire logic                       rst,
   // configuration
   input wire logic                       begin_measure_bit,
   input wire logic                       meas_mode2,
   input wire logic [CNT_W/2-1:0]         early_edge_blank_hi,
   input wire logic [CNT_W/2-1:0]         early_edge_blank_lo,
   // outputs watched
   input wire logic                       launch_pulse_out,
   input wire logic                       done_irq_n,
   input wire logic                       ring_run,
   input wire logic [NUM_CYC-1:0][CNT_W-1:0] ref_cycle_result,
   input wire logic                       wrap_limit_flag,
   input wire logic                       cycle_limit_flag,
   input wire logic                       busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [CNT_W-1:0] blank;
   assign blank = {early_edge_blank_hi, early_edge_blank_lo};
   // ----------------
   // sequences
   // ----------------
   sequence arm_s;
      !busy && begin_measure_bit;
   endsequence
   sequence armed_s;
      launch_pulse_out && busy;
   endsequence
   sequence flag_up_s;
      $rose(wrap_limit_flag || cycle_limit_flag);
   endsequence
   // ----------------
   // properties
   // ----------------
   arm_launch_a: assert property (arm_s |=> armed_s)
      else $error("trigger not raised after start request");
   armed_quiet_a: assert property (launch_pulse_out |-> busy && !ring_run && done_irq_n)
      else $error("ring or irq active while armed");
   done_quiet_a: assert property (!done_irq_n |-> !launch_pulse_out && !busy && !ring_run)
      else $error("pins still active after completion");
   done_hold_a: assert property (!done_irq_n && !begin_measure_bit |=> !done_irq_n)
      else $error("interrupt released without new request");
   flag_irq_a: assert property (flag_up_s |-> ##[0:1] !done_irq_n)
      else $error("limit flag without interrupt");
   flag_abort_a: assert property (flag_up_s |=> !busy)
      else $error("measurement not aborted on limit");
   cycle_mode_a: assert property ($rose(cycle_limit_flag) |-> meas_mode2)
      else $error("cycle limit flag outside mode two");
   cycle_mode2_a: assert property ($changed(ref_cycle_result) && ref_cycle_result != '0
      |-> meas_mode2) else $error("cycle result written in mode one");
   blank_win_a: assert property ($changed(ref_cycle_result[0])
      && ref_cycle_result[0] != CNT_ZERO |-> ref_cycle_result[0] >= blank)
      else $error("stop accepted inside blank window");
endmodule

bind swt_core swt_core_monitor swt_core_monitor_i (.clk, .rst, .begin_measure_bit,
   .meas_mode2, .early_edge_blank_hi, .early_edge_blank_lo, .launch_pulse_out,
   .done_irq_n, .ring_run, .ref_cycle_result, .wrap_limit_flag, .cycle_limit_flag, .busy);

// ==== testbench/swt_fe_model.sv ====
`timescale 1ns/1ps
module swt_fe_model
   import swt_pkg::*;
(
   // clock and device pins
   input wire logic                clk,
   input wire logic                launch_pulse_out,
   input wire logic                ring_run,
   // bench commands
   input wire logic                fire_stop,
   input wire logic                hold_start,
   // pins toward the core
   output logic                    start_pin,
   output logic                    stop_pin,
   output logic                    ring_wrap_tgl,
   output logic [PHASE_W-1:0]      ring_phase
);
   logic [3:0] lc_r = 4'h0;
   logic       stop_d_r = 1'b0;
   initial start_pin = 1'b0;
   initial stop_pin = 1'b0;
   initial ring_wrap_tgl = 1'b0;
   // fixed phase keeps every fine result at a known remainder
   assign ring_phase = 6'h15;
   // ----------------
   // start and stop pulses, two cycles wide
   // ----------------
   always @(posedge clk) begin
      if (!launch_pulse_out || hold_start)
         lc_r <= 4'h0;
      else if (lc_r != 4'h7)
         lc_r <= lc_r + 4'h1;
      start_pin <= (lc_r == 4'h2) || (lc_r == 4'h3);
      stop_d_r <= fire_stop;
      stop_pin <= fire_stop || stop_d_r;
   end
   // ----------------
   // ring: one wrap per clock while enabled
   // ----------------
   always @(negedge clk) begin
      if (ring_run)
         ring_wrap_tgl <= ~ring_wrap_tgl;
   end
endmodule

// ==== testbench/swt_core_tb.sv ====
`timescale 1ns/1ps
module swt_core_tb;
   import swt_pkg::*;
   logic clk = 0, rst = 1, begin_measure_bit = 0, meas_mode2 = 0, fire_stop = 0, hold_start = 0;
   logic [IDX_W-1:0] stop_count = 3'h1;
   logic [LEN_W-1:0] cal_multi_len = 8'h0a;
   logic [7:0] wrap_limit_hi = 8'hff, wrap_limit_lo = 8'hff, cycle_limit_hi = 8'h10;
   logic [7:0] cycle_limit_lo = 8'h00, early_edge_blank_hi = 8'h00, early_edge_blank_lo = 8'h00;
   logic start_pin, stop_pin, launch_pulse_out, done_irq_n, ring_wrap_tgl, ring_run, busy;
   logic wrap_limit_flag, cycle_limit_flag;
   logic [PHASE_W-1:0] ring_phase;
   logic [NUM_FINE-1:0][FINE_W-1:0] fine_result;
   logic [NUM_CYC-1:0][CNT_W-1:0] ref_cycle_result;
   logic [FINE_W-1:0] cal_single_count, cal_multi_count;
   int err_count = 0, num_checks = 0, cyc = 0, n;

   always #4 clk = ~clk;

   swt_core swt_core_i (.clk, .rst, .begin_measure_bit, .meas_mode2, .stop_count,
      .cal_multi_len, .wrap_limit_hi, .wrap_limit_lo, .cycle_limit_hi, .cycle_limit_lo,
      .early_edge_blank_hi, .early_edge_blank_lo, .start_pin, .stop_pin, .launch_pulse_out,
      .done_irq_n, .ring_wrap_tgl, .ring_phase, .ring_run, .fine_result, .ref_cycle_result,
      .cal_single_count, .cal_multi_count, .wrap_limit_flag, .cycle_limit_flag, .busy);
   swt_fe_model swt_fe_model_i (.clk, .launch_pulse_out, .ring_run, .fire_stop, .hold_start,
      .start_pin, .stop_pin, .ring_wrap_tgl, .ring_phase);

   // ----------------
   // helpers
   // ----------------
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic go(logic mode, logic [2:0] cnt);
      @(negedge clk);
      meas_mode2 = mode;
      stop_count = cnt;
      begin_measure_bit = 1;
      @(negedge clk);
      begin_measure_bit = 0;
      for (int i = 0; i < 50 && launch_pulse_out !== 1'b0; i++) @(negedge clk);
   endtask
   task automatic stop_at(int k);
      repeat (k) @(negedge clk);
      fire_stop = 1;
      @(negedge clk);
      fire_stop = 0;
   endtask
   task automatic wait_done(output int c);
      for (c = 0; c < 2000 && done_irq_n !== 1'b0; c++) @(negedge clk);
      chk("done_irq_n", 32'h0, {31'h0, done_irq_n});
   endtask
   task automatic idle_pins;
      chk("launch", 32'h0, {31'h0, launch_pulse_out});
      chk("busy", 32'h0, {31'h0, busy});
      chk("ring_run", 32'h0, {31'h0, ring_run});
   endtask
   // ----------------
   // scenarios
   // ----------------
   task automatic t_reset;
      idle_pins();
      chk("irq after reset", 32'h1, {31'h0, done_irq_n});
   endtask
   task automatic t_mode1;
      go(1'b0, 3'h3);
      stop_at(25);
      stop_at(5);
      stop_at(5);
      wait_done(n);
      idle_pins();
      chk("fine0 rem", 32'd21, 32'(fine_result[0] % WRAP_UNITS));
      chk("fine order a", 32'h1, {31'h0, fine_result[0] < fine_result[1]});
      chk("fine order b", 32'h1, {31'h0, fine_result[1] < fine_result[2]});
      chk("fine3", 32'h0, 32'(fine_result[3]));
      chk("cyc0 mode1", 32'h0, 32'(ref_cycle_result[0]));
      chk("cal order", 32'h1, {31'h0, cal_multi_count > cal_single_count});
      chk("cal nonzero", 32'h1, {31'h0, cal_single_count != FINE_ZERO});
   endtask
   task automatic t_mode2;
      early_edge_blank_lo = 8'd20;
      go(1'b1, 3'h0);
      stop_at(8);
      stop_at(40);
      wait_done(n);
      chk("cyc0 low", 32'h1, {31'h0, ref_cycle_result[0] >= 16'd45});
      chk("cyc0 high", 32'h1, {31'h0, ref_cycle_result[0] <= 16'd60});
      chk("cyc1", 32'h0, 32'(ref_cycle_result[1]));
      chk("start frac", 32'h1, {31'h0, fine_result[0] < 23'd252});
      chk("start rem", 32'd21, 32'(fine_result[0] % WRAP_UNITS));
      chk("stop rem", 32'd21, 32'(fine_result[1] % WRAP_UNITS));
      chk("cal order2", 32'h1, {31'h0, cal_multi_count > cal_single_count});
   endtask
   task automatic t_wrap;
      wrap_limit_hi = 8'h00;
      wrap_limit_lo = 8'h05;
      go(1'b0, 3'h1);
      wait_done(n);
      chk("wrap flag", 32'h1, {31'h0, wrap_limit_flag});
      chk("wrap early", 32'h1, {31'h0, n <= 25});
      idle_pins();
      wrap_limit_hi = 8'hff;
   endtask
   task automatic t_cyc;
      cycle_limit_hi = 8'h00;
      cycle_limit_lo = 8'd30;
      early_edge_blank_lo = 8'd10;
      go(1'b1, 3'h1);
      wait_done(n);
      chk("cycle flag", 32'h1, {31'h0, cycle_limit_flag});
      chk("wrap cleared", 32'h0, {31'h0, wrap_limit_flag});
      chk("cycle late", 32'h1, {31'h0, n >= 25 && n <= 50});
      cycle_limit_hi = 8'h10;
   endtask
   task automatic t_nostart;
      hold_start = 1;
      go(1'b0, 3'h1);
      repeat (200) @(negedge clk);
      chk("launch wait", 32'h1, {31'h0, launch_pulse_out});
      chk("busy wait", 32'h1, {31'h0, busy});
   endtask
   task automatic t_midreset;
      rst = 1;
      repeat (5) @(negedge clk);
      rst = 0;
      hold_start = 0;
      t_reset();
      chk("flag reset", 32'h0, {31'h0, cycle_limit_flag});
      chk("fine reset", 32'h0, 32'(fine_result[0]));
      chk("cyc reset", 32'h0, 32'(ref_cycle_result[0]));
   endtask
   // ----------------
   // run control
   // ----------------
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         $display("FAIL timeout expected 0 seen %0d", cyc);
         print_verdict();
      end
   end
   initial begin
      repeat (5) @(negedge clk);
      rst = 0;
      t_reset();
      t_mode1();
      t_mode2();
      t_wrap();
      t_cyc();
      t_nostart();
      t_midreset();
      print_verdict();
   end
endmodule
